// ### hdl/filt_chain_pkg.sv
// constants and types of the sampled filter and integration chain
// Operation
// R1: every filter steps once per sample tick
// R2: all channels processed in lockstep with sampling
// R3: sampling instants track the measured waveform
// R4: flat linear band from 0,5 Hz to 6 kHz
// R5: no saturation, wide intermediate values
// R6: sample rate kept high enough against aliasing
// R7: record stream carries every sample by default
// R8: under-sampling only behind a software enable
// R9: records include raw currents before integration
// R10: configurable first-order high-pass and integrator
// R11: integrate band between the two cut-offs
// R12: raw derivative currents as separate stream
// R13: residual sums of three phase channels
// R14: per-input direct or derivative current mode
// R15: configuration applied only on sample boundaries
// R16: one valid output per tick, consumed together
package filt_chain_pkg;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned BAND_HI_HZ    = 6000;
  localparam int unsigned MIN_SAMPLE_HZ = 2 * BAND_HI_HZ;
  localparam int unsigned MAX_PERIOD    = CLK_HZ / MIN_SAMPLE_HZ;
  localparam int unsigned NOM_SAMPLE_HZ = 12800;
  localparam int unsigned NOM_PERIOD    = CLK_HZ / NOM_SAMPLE_HZ;
  localparam int unsigned MIN_PERIOD    = 4;
  // -----------------------------------------------------------------
  // widths and counts
  // -----------------------------------------------------------------
  localparam int NCUR = 3;
  localparam int NVOLT = 4;
  localparam int SW = 16;
  localparam int FW = 32;
  localparam int CW = 16;
  localparam int QF = 15;
  localparam int PW = 16;
  localparam int UW = 8;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [CW-1:0] HP_A_RST = 16'h7FF8;
  localparam logic [CW-1:0] LP_K_RST = 16'h0050;
  localparam logic [CW-1:0] LP_C_RST = 16'h0050;
  localparam logic [UW-1:0] US_RATIO_RST = 8'h01;
  // -----------------------------------------------------------------
  // types
  // -----------------------------------------------------------------
  typedef logic signed [SW-1:0] smp_t;
  typedef logic signed [FW-1:0] fil_t;
  typedef logic signed [CW-1:0] coef_t;
  typedef logic signed [FW+1:0] res_i_t;
  typedef logic signed [SW+1:0] res_v_t;
  typedef smp_t [NCUR-1:0] cur_raw_t;
  typedef struct packed {
    logic [NCUR-1:0] deriv_mode;
    coef_t           hp_a;
    coef_t           lp_k;
    coef_t           lp_c;
    logic            us_en;
    logic [UW-1:0]   us_ratio;
  } cfg_s;
  typedef struct packed {
    cur_raw_t          cur;
    smp_t [NVOLT-1:0]  volt;
  } samples_s;
  typedef struct packed {
    fil_t [NCUR-1:0]   cur;
    smp_t [NVOLT-1:0]  volt;
    res_i_t            res_i;
    res_v_t            res_v;
    cur_raw_t          raw;
  } out_s;
  typedef struct packed {
    smp_t x_prev;
    fil_t hp;
    fil_t lp;
  } filt_state_s;
  typedef struct packed {
    cfg_s          cfg;
    logic [PW-1:0] per;
    logic [PW-1:0] cnt;
    logic          adc_start;
    samples_s      smp;
    logic          d1;
    out_s          out;
    logic          valid;
    logic [UW-1:0] us_cnt;
    logic          rec_valid;
    logic          deriv_valid;
    cur_raw_t      deriv;
  } top_state_s;
endpackage

// ### hdl/filt_chain.sv
// derivative-current integration filters and the sampled output chain
`timescale 1ns/1ns
// -------------------------------------------------------------------
// one high-pass plus leaky integrator channel
// -------------------------------------------------------------------
module integ_stage (
  input  logic                 i_clk,
  input  logic                 i_srst,
  input  logic                 i_step,
  input  logic                 i_clear,
  input  filt_chain_pkg::smp_t  i_x,
  input  filt_chain_pkg::coef_t i_hp_a,
  input  filt_chain_pkg::coef_t i_lp_k,
  input  filt_chain_pkg::coef_t i_lp_c,
  output filt_chain_pkg::fil_t  o_y
);
  import filt_chain_pkg::*;
  filt_state_s s;
  filt_state_s n;
  fil_t hp_sum;
  fil_t hp_n;
  logic signed [FW+CW-1:0] p1;
  logic signed [FW+CW-1:0] p2;
  logic signed [FW+CW-1:0] p3;

  always_comb begin
    n = s;
    hp_sum = s.hp + fil_t'(i_x) - fil_t'(s.x_prev);
    p1 = hp_sum * i_hp_a;
    hp_n = p1[QF+FW-1:QF];
    p2 = hp_n * i_lp_k;
    p3 = s.lp * i_lp_c;
    if (i_srst) begin
      n = '0;
    end else if (i_step) begin // R1
      if (i_clear) begin
        n = '0;
      end else begin
        // first-order high-pass, wide state keeps headroom
        n.x_prev = i_x; // R10
        n.hp = hp_n; // R5
        // integrate with leak: gain k, pole set by c
        n.lp = s.lp + fil_t'(p2[QF+FW-1:QF])
             - fil_t'(p3[QF+FW-1:QF]); // R11
      end
    end
  end

  always_ff @(posedge i_clk) begin
    s <= n;
  end

  assign o_y = s.lp;

  step_only_a: assert property (@(posedge i_clk) disable iff (i_srst) // R1
    !i_step |=> $stable(s))
    else $error("filter state moved without a sample tick");
endmodule

`timescale 1ns/1ns
// -------------------------------------------------------------------
// top: sample timer, config shadow, filters, residuals, records
// -------------------------------------------------------------------
module filt_chain (
  input  logic                        i_clk,
  input  logic                        i_srst,
  input  filt_chain_pkg::cfg_s        i_cfg,
  input  logic [filt_chain_pkg::PW-1:0] i_track_period,
  input  logic                        i_sample_valid,
  input  filt_chain_pkg::samples_s    i_samples,
  output logic                        o_adc_start,
  output logic                        o_valid,
  output filt_chain_pkg::out_s        o_out,
  output logic                        o_rec_valid,
  output logic                        o_deriv_valid,
  output filt_chain_pkg::cur_raw_t    o_deriv
);
  import filt_chain_pkg::*;
  top_state_s s;
  top_state_s n;
  fil_t [NCUR-1:0] y;
  logic [PW-1:0] per_req;

  // -----------------------------------------------------------------
  // filter channels, all stepped by the same tick
  // -----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NCUR; g++) begin : g_ch
      integ_stage u_stage (
        .i_clk   (i_clk),
        .i_srst  (i_srst),
        .i_step  (i_sample_valid), // R1
        .i_clear (~s.cfg.deriv_mode[g]), // R14
        .i_x     (i_samples.cur[g]),
        .i_hp_a  (s.cfg.hp_a), // R15
        .i_lp_k  (s.cfg.lp_k),
        .i_lp_c  (s.cfg.lp_c),
        .o_y     (y[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    n = s;
    per_req = i_track_period;
    // clamp keeps rate above the aliasing limit
    if (per_req > PW'(MAX_PERIOD)) begin // R6
      per_req = PW'(MAX_PERIOD);
    end else if (per_req < PW'(MIN_PERIOD)) begin
      per_req = PW'(MIN_PERIOD);
    end
    // sample timer, new period only at wrap
    if (s.cnt >= s.per - PW'(1)) begin // R3
      n.cnt = '0;
      n.adc_start = 1'b1;
      n.per = per_req; // R4
    end else begin
      n.cnt = s.cnt + PW'(1);
      n.adc_start = 1'b0;
    end
    n.d1 = i_sample_valid;
    if (i_sample_valid) begin
      n.smp = i_samples;
      n.cfg = i_cfg; // R15
    end
    n.valid = s.d1; // R16
    n.deriv_valid = s.d1; // R12
    n.rec_valid = 1'b0;
    if (s.d1) begin // R2
      for (int i = 0; i < NCUR; i++) begin
        if (s.cfg.deriv_mode[i]) begin
          n.out.cur[i] = y[i]; // R14
        end else begin
          n.out.cur[i] = fil_t'($signed(s.smp.cur[i]));
        end
      end
      n.out.volt = s.smp.volt;
      n.out.raw = s.smp.cur; // R9
      n.deriv = s.smp.cur; // R12
      n.out.res_i = res_i_t'($signed(n.out.cur[0]))
                  + res_i_t'($signed(n.out.cur[1]))
                  + res_i_t'($signed(n.out.cur[2])); // R13
      n.out.res_v = res_v_t'($signed(s.smp.volt[0]))
                  + res_v_t'($signed(s.smp.volt[1]))
                  + res_v_t'($signed(s.smp.volt[2])); // R13
      // record decimation, every sample unless enabled
      if (!s.cfg.us_en) begin // R7
        n.rec_valid = 1'b1;
        n.us_cnt = '0;
      end else if (s.us_cnt == '0) begin // R8
        n.rec_valid = 1'b1;
        if (s.cfg.us_ratio == '0) begin
          n.us_cnt = '0;
        end else begin
          n.us_cnt = s.cfg.us_ratio - UW'(1);
        end
      end else begin
        n.us_cnt = s.us_cnt - UW'(1);
      end
    end
    if (i_srst) begin
      n = '0;
      n.per = PW'(NOM_PERIOD);
      n.cfg.hp_a = HP_A_RST;
      n.cfg.lp_k = LP_K_RST;
      n.cfg.lp_c = LP_C_RST;
      n.cfg.us_ratio = US_RATIO_RST;
    end
  end

  always_ff @(posedge i_clk) begin
    s <= n;
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  assign o_adc_start = s.adc_start;
  assign o_valid = s.valid;
  assign o_out = s.out;
  assign o_rec_valid = s.rec_valid;
  assign o_deriv_valid = s.deriv_valid;
  assign o_deriv = s.deriv;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence tick_seq;
    i_sample_valid;
  endsequence

  sequence out_seq;
    ##2 (o_valid && o_deriv_valid);
  endsequence

  tick_to_out_a: assert property (tick_seq |-> out_seq) // R16
    else $error("no output two cycles after a sample");
  out_from_tick_a: assert property ( // R2
    o_valid |-> $past(i_sample_valid, 2))
    else $error("output without a sample two cycles before");
  res_volt_a: assert property (o_valid |-> o_out.res_v == // R13
    res_v_t'($signed(o_out.volt[0])) + res_v_t'($signed(o_out.volt[1]))
    + res_v_t'($signed(o_out.volt[2])))
    else $error("residual voltage is not the phase sum");
  res_cur_a: assert property (o_valid |-> o_out.res_i == // R13
    res_i_t'($signed(o_out.cur[0])) + res_i_t'($signed(o_out.cur[1]))
    + res_i_t'($signed(o_out.cur[2])))
    else $error("residual current is not the phase sum");
  rec_full_a: assert property ( // R7
    (o_valid && !s.cfg.us_en) |-> o_rec_valid)
    else $error("sample dropped from record stream");
  rec_gate_a: assert property (o_rec_valid |-> o_valid) // R8
    else $error("record strobe without output");
  raw_rec_a: assert property ( // R9
    o_valid |-> (o_out.raw == o_deriv) && $past(o_deriv_valid) == 1'b0)
    else $error("raw currents differ from derivative stream");
  cfg_hold_a: assert property (!i_sample_valid |=> $stable(s.cfg)) // R15
    else $error("configuration changed between samples");
  period_lim_a: assert property ( // R6
    s.per <= PW'(MAX_PERIOD) && s.per >= PW'(MIN_PERIOD))
    else $error("sample period outside allowed range");
  start_gap_a: assert property (o_adc_start |=> !o_adc_start [*3]) // R3
    else $error("conversion starts too close together");
  direct_cur_a: assert property ( // R14
    (o_valid && !s.cfg.deriv_mode[0])
    |-> o_out.cur[0] == fil_t'($signed(o_out.raw[0])))
    else $error("direct current input not passed through");
endmodule

// ### testbench/adc_model.sv
// partner model: sampling front end answering each conversion start
`timescale 1ns/1ns
module adc_model (
  input  wire logic               i_clk,
  input  wire logic               i_start,
  input  wire logic               i_slow,
  output filt_chain_pkg::samples_s o_samples,
  output logic                    o_valid
);
  import filt_chain_pkg::*;
  int seed = 84131;
  int wcnt = -1;
  initial begin
    o_valid = 1'b0;
    o_samples = '0;
  end
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    // lines keep moving outside a frame
    o_samples <= ~o_samples;
    if (i_start) wcnt = i_slow ? 2 : 0;
    else if (wcnt > 0) wcnt--;
    else if (wcnt == 0) begin
      wcnt = -1;
      o_valid <= 1'b1;
      for (int i = 0; i < NCUR + NVOLT; i++)
        o_samples[i*SW +: SW] <= SW'($random(seed));
    end
  end
endmodule

// ### testbench/sampled_filter_integration_chain_tb.sv
// self-checking bench of the filter chain against a behavioural model
`timescale 1ns/1ns
module sampled_filter_integration_chain_tb;
  import filt_chain_pkg::*;
  logic          i_clk = 0;
  logic          i_srst = 1;
  logic          i_slow = 0;
  cfg_s          i_cfg;
  logic [PW-1:0] i_track_period;
  logic          i_sample_valid;
  samples_s      i_samples;
  logic          o_adc_start, o_valid, o_rec_valid, o_deriv_valid;
  out_s          o_out;
  cur_raw_t      o_deriv;
  int fails = 0, samples_checked = 0, seed = 84131, cyc = 0;
  int last = -1, eper = 0, trk = 0, uc = 0;
  int hp[NCUR], lp[NCUR], xp[NCUR];
  cfg_s pcfg;
  out_s q[$];
  int qc[$];
  bit qr[$];
  logic [PW-1:0] per[7] = '{16'h00C8, 16'h0004, 16'h0002, 16'h1388,
                            16'h0004, 16'h012C, 16'h0021};
  always #10 i_clk = ~i_clk;
  filt_chain dut (.i_clk, .i_srst, .i_cfg, .i_track_period,
    .i_sample_valid, .i_samples, .o_adc_start, .o_valid, .o_out,
    .o_rec_valid, .o_deriv_valid, .o_deriv);
  adc_model prt (.i_clk, .i_start(o_adc_start), .i_slow,
    .o_samples(i_samples), .o_valid(i_sample_valid));
  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_out(input out_s e, input out_s g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_val(input logic [47:0] e, input logic [47:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic int m15(logic signed [CW-1:0] c, int v);
    longint p;
    p = c * longint'(v);
    return int'(p >>> 15);
  endfunction
  // ---------------------------------------------------------------
  // reference model, scoreboard and sample timer check
  // ---------------------------------------------------------------
  always @(posedge i_clk) begin
    out_s e;
    longint ri;
    int x;
    bit r;
    cyc++;
    if (i_srst) begin
      hp = '{default:0};
      lp = '{default:0};
      xp = '{default:0};
      pcfg = '{3'h0, HP_A_RST, LP_K_RST, LP_C_RST, 1'b0, US_RATIO_RST};
      uc = 0;
      last = -1;
      q.delete();
      qc.delete();
      qr.delete();
    end else begin
      if (o_valid | o_deriv_valid) chk_val(o_deriv_valid, o_valid);
      if (o_valid) begin
        if (q.size() == 0) chk_val(1, 0);
        else begin
          chk_val(2, cyc - qc.pop_front());
          e = q.pop_front();
          chk_out(e, o_out);
          chk_val(qr.pop_front(), o_rec_valid);
          chk_val(e.raw, o_deriv);
        end
      end
      if (i_sample_valid) begin
        e = '0;
        ri = 0;
        for (int c = 0; c < NCUR; c++) begin
          x = i_samples.cur[c];
          // filter steps under the mode latched at the previous tick
          if (pcfg.deriv_mode[c]) begin
            hp[c] = m15(pcfg.hp_a, hp[c] + x - xp[c]);
            lp[c] = lp[c] + m15(pcfg.lp_k, hp[c]) - m15(pcfg.lp_c, lp[c]);
            xp[c] = x;
          end else begin
            hp[c] = 0;
            lp[c] = 0;
            xp[c] = 0;
          end
          // output selection follows the mode latched at this tick
          if (i_cfg.deriv_mode[c]) x = lp[c];
          e.cur[c] = x;
          ri += x;
        end
        e.volt = i_samples.volt;
        e.raw = i_samples.cur;
        e.res_i = res_i_t'(ri);
        e.res_v = i_samples.volt[0] + i_samples.volt[1] + i_samples.volt[2];
        r = !i_cfg.us_en || uc == 0;
        if (!i_cfg.us_en) uc = 0;
        else if (!r) uc--;
        else uc = (i_cfg.us_ratio == 0) ? 0 : i_cfg.us_ratio - 1;
        q.push_back(e);
        qc.push_back(cyc);
        qr.push_back(r);
        pcfg = i_cfg;
      end
      if (o_adc_start) begin
        if (last >= 0) chk_val(eper, cyc - last);
        last = cyc;
        eper = trk;
      end
    end
    trk = i_track_period < MIN_PERIOD ? MIN_PERIOD :
          i_track_period > MAX_PERIOD ? MAX_PERIOD : i_track_period;
  end
  task automatic wait_out(int n);
    int k;
    while (n > 0) begin
      k = 0;
      do begin
        @(posedge i_clk);
        #1;
        if (++k > 5000) begin
          fails++;
          end_sim();
        end
      end while (o_valid !== 1'b1);
      n--;
    end
  endtask
  initial begin
    i_cfg = '0;
    i_track_period = 16'h00C8;
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (per[p]) begin
      @(posedge i_clk);
      i_cfg <= {3'($random(seed)), 1'b0, 15'($random(seed)), 4'h0,
                12'($random(seed)), 4'h0, 12'($random(seed)),
                1'($random(seed)), 5'h00, 3'($random(seed))};
      i_track_period <= per[p];
      i_slow <= p[0] && per[p] > 16'h0028;
      wait_out(6);
    end
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_srst <= 1'b0;
    i_cfg.deriv_mode <= 3'h7;
    wait_out(4);
    end_sim();
  end
endmodule
